// >>> inc/fsd_map.vh
// register map, field positions and timing constants for the fault/status display supervisor
`ifndef FSD_MAP_VH
`define FSD_MAP_VH
// register byte offsets
`define FSD_CTRL_OFF 12'h000
`define FSD_STAT_OFF 12'h004
`define FSD_CODE_OFF 12'h008
`define FSD_FLT_OFF 12'h00C
`define FSD_STEP_OFF 12'h010
`define FSD_FLE_OFF 12'h014
// control fields
`define FSD_CTRL_CFG 0
`define FSD_CTRL_HOST_DIS 1
`define FSD_CTRL_BRUSH 2
`define FSD_CTRL_POSMODE 3
// status fields
`define FSD_STAT_EN 0
`define FSD_STAT_FATAL 1
`define FSD_STAT_NONFATAL 2
`define FSD_STAT_PWR 3
// reset values
`define FSD_CTRL_RST 32'h0000_0000
`define FSD_STEP_RST 32'h0098_9680
`define FSD_FLE_RST 32'h0000_1000
// timing
`define FSD_SAT_TIME_MS 1000
`define FSD_CLK_KHZ 50000
// display character codes (4 bit: 0-9 digits)
`define FSD_CH_F 4'hA
`define FSD_CH_L 4'hB
`define FSD_CH_D 4'hC
`define FSD_CH_E 4'hD
`define FSD_CH_P 4'hE
`define FSD_CH_BLANK 4'hF
`endif

// >>> hdl/fsd_supervisor.v
// fault and status display supervisor with apb register slave
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "fsd_map.vh"
// Contract
// R1: idle shows d disabled, E enabled
// R2: status condition flashes three-character code
// R3: any fault disables power stage immediately
// R4: fault shown as flashing F plus two digits
// R5: fatal fault latched until power cycle, enable
// R6: non-fatal cleared by enable removal then reassertion
// R7: highest priority shown, fatal, non-fatal, status
// R8: F00-F03 codes for processor, switch, bridge, feedback
// R9: F04 on regulation fault or saturation one second
// R10: F05 on heat sink above ninety degrees
// R11: F06 on motor thermostat trip
// R12: F51-F54, F56, F57 non-fatal codes
// R13: brushless-only faults masked for brush motor
// R14: F55 only in position modes at limit
// R15: unconfigured shows F99, cannot enable
// R16: L01/L02 on limit when enabled, no fault
// R17: P shown while phasing in progress
// R18: d when host or input disables, no fault
// R19: host may disable; enable needs input active
// R20: characters shown in turn, blank gap after
module fsd_supervisor #(
  parameter SAT_CYCLES = `FSD_SAT_TIME_MS * `FSD_CLK_KHZ,
  parameter STEP_W = 32
) (
  input wire ref_clk,
  input wire rst,
  input wire pwr_on_n,
  input wire enable_in,
  input wire [6:0] fatal_in,
  input wire [6:0] nonfatal_in,
  input wire cur_sat,
  input wire [31:0] follow_err,
  input wire phasing,
  input wire limit_cw,
  input wire limit_ccw,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg amp_en,
  output reg [3:0] disp_char,
  output reg disp_on
);

  // ==========================================================
  // code helpers
  // packs a display code: three 4-bit characters and a flash flag
  function [12:0] code3;
    input flash;
    input [3:0] c0;
    input [3:0] c1;
    input [3:0] c2;
    begin
      code3 = {flash, c0, c1, c2};
    end
  endfunction

  // ==========================================================
  // registers
  reg [3:0] ctrl_q;
  reg [STEP_W-1:0] step_q;
  reg [31:0] fle_q;
  reg [6:0] fatal_q;
  reg [7:0] nonfatal_q;
  reg en_q;
  reg en_in_q;
  reg pwr_q;
  reg [31:0] sat_cnt_q;
  reg [STEP_W-1:0] tick_q;
  reg [1:0] pos_q;
  reg [12:0] code_q;
  wire cfg = ctrl_q[`FSD_CTRL_CFG];
  wire brush = ctrl_q[`FSD_CTRL_BRUSH];
  wire any_fault = (|fatal_q) | (|nonfatal_q);
  wire sat_trip = (sat_cnt_q >= SAT_CYCLES - 1) & cur_sat;

  // ==========================================================
  // fault sources after masking
  reg [6:0] fatal_raw;
  reg [7:0] nonfatal_raw;
  always @* begin
    fatal_raw = fatal_in; // [R8] [R10] [R11]
    fatal_raw[4] = fatal_in[4] | sat_trip; // [R9]
    nonfatal_raw = {1'b0, nonfatal_in};
    nonfatal_raw[0] = nonfatal_in[0] & ~brush; // [R13]
    nonfatal_raw[6] = 1'b0; // no fault source on this bit
    // bit 7 is following error, position modes only
    nonfatal_raw[7] = ctrl_q[`FSD_CTRL_POSMODE] & (follow_err >= fle_q); // [R14]
  end

  // ==========================================================
  // saturation timer
  always @(posedge ref_clk) begin
    if (rst | ~cur_sat) begin
      sat_cnt_q <= 32'h0000_0000;
    end else if (~sat_trip) begin
      sat_cnt_q <= sat_cnt_q + 32'h0000_0001; // [R9]
    end
  end

  // ==========================================================
  // enable edge, power-down marker, fault latches and enable state
  wire en_rise = enable_in & ~en_in_q;
  wire fatal_clr = pwr_q & ~pwr_on_n & en_rise;
  wire fault_now = any_fault | (|fatal_raw) | (|nonfatal_raw);

  // enable input held one edge for rising-edge detection
  always @(posedge ref_clk) begin
    if (rst) begin
      en_in_q <= 1'b0;
    end else begin
      en_in_q <= enable_in;
    end
  end

  // power-down marker, used up by the fatal clear
  always @(posedge ref_clk) begin
    if (rst) begin
      pwr_q <= 1'b0;
    end else if (fatal_clr) begin
      pwr_q <= 1'b0;
    end else if (pwr_on_n) begin
      pwr_q <= 1'b1; // power removed seen
    end
  end

  // fatal latch: reload only after power cycle and enable
  always @(posedge ref_clk) begin
    if (rst) begin
      fatal_q <= 7'h00;
    end else if (fatal_clr) begin
      fatal_q <= fatal_raw; // [R5]
    end else begin
      fatal_q <= fatal_q | fatal_raw; // [R5]
    end
  end

  // non-fatal latch: reload at each enable rising edge
  always @(posedge ref_clk) begin
    if (rst) begin
      nonfatal_q <= 8'h00;
    end else if (en_rise) begin
      nonfatal_q <= nonfatal_raw; // [R6] fresh check at re-enable
    end else begin
      nonfatal_q <= nonfatal_q | nonfatal_raw; // [R6]
    end
  end

  // internal enable: input high, configured, no fault, no host disable
  always @(posedge ref_clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable_in & cfg & ~ctrl_q[`FSD_CTRL_HOST_DIS] & ~fault_now; // [R15] [R19] [R3]
    end
  end

  // ==========================================================
  // priority selection of displayed code
  reg [12:0] code_d;
  // lowest priority first, so each later match overwrites
  always @* begin
    code_d = en_q ? code3(1'b0, `FSD_CH_E, `FSD_CH_BLANK, `FSD_CH_BLANK)
      : code3(1'b0, `FSD_CH_D, `FSD_CH_BLANK, `FSD_CH_BLANK); // [R1] [R18]
    if (phasing) begin
      code_d = code3(1'b0, `FSD_CH_P, `FSD_CH_BLANK, `FSD_CH_BLANK); // [R17]
    end
    if (en_q & limit_ccw) begin
      code_d = code3(1'b1, `FSD_CH_L, 4'h0, 4'h2); // [R16] [R2]
    end
    if (en_q & limit_cw) begin
      code_d = code3(1'b1, `FSD_CH_L, 4'h0, 4'h1); // [R16] [R2]
    end
    if (~cfg) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h9, 4'h9); // [R15]
    end
    // non-fatal faults, F57 up to F51
    if (nonfatal_q[5]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h7); // [R12] [R7]
    end
    if (nonfatal_q[4]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h6); // [R12] [R7]
    end
    if (nonfatal_q[7]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h5); // [R14] [R7]
    end
    if (nonfatal_q[3]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h4); // [R12] [R7]
    end
    if (nonfatal_q[2]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h3); // [R12] [R7]
    end
    if (nonfatal_q[1]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h2); // [R12] [R7]
    end
    if (nonfatal_q[0]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h5, 4'h1); // [R12] [R7]
    end
    // fatal faults, F06 up to F00
    if (fatal_q[6]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h6); // [R11] [R4] [R7]
    end
    if (fatal_q[5]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h5); // [R10] [R4] [R7]
    end
    if (fatal_q[4]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h4); // [R9] [R4] [R7]
    end
    if (fatal_q[3]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h3); // [R8] [R4] [R7]
    end
    if (fatal_q[2]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h2); // [R8] [R4] [R7]
    end
    if (fatal_q[1]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h1); // [R8] [R4] [R7]
    end
    if (fatal_q[0]) begin
      code_d = code3(1'b1, `FSD_CH_F, 4'h0, 4'h0); // [R8] [R4] [R7]
    end
  end

  // ==========================================================
  // display sequencer: flashing codes step through c0,c1,c2,blank
  localparam POS_C0 = 2'b00;
  localparam POS_C1 = 2'b01;
  localparam POS_C2 = 2'b10;
  localparam POS_GAP = 2'b11;
  // character position advance, power stage and display outputs
  always @(posedge ref_clk) begin
    if (rst) begin
      code_q <= 13'h0000;
      tick_q <= {STEP_W{1'b0}};
      pos_q <= POS_C0;
      disp_char <= `FSD_CH_BLANK;
      disp_on <= 1'b0;
      amp_en <= 1'b0;
    end else begin
      amp_en <= en_q & enable_in & ~fault_now; // [R3] [R19]
      code_q <= code_d;
      if (code_d != code_q) begin
        tick_q <= {STEP_W{1'b0}};
        pos_q <= POS_C0;
      end else if (tick_q >= step_q) begin
        tick_q <= {STEP_W{1'b0}};
        pos_q <= pos_q + 2'b01; // [R20]
      end else begin
        tick_q <= tick_q + {{(STEP_W-1){1'b0}}, 1'b1};
      end
      if (~code_q[12]) begin
        disp_char <= code_q[11:8]; // [R1] steady single character
        disp_on <= 1'b1;
      end else begin
        case (pos_q)
          POS_C0: begin
            disp_char <= code_q[11:8]; // [R2] [R4]
            disp_on <= 1'b1;
          end
          POS_C1: begin
            disp_char <= code_q[7:4];
            disp_on <= 1'b1;
          end
          POS_C2: begin
            disp_char <= code_q[3:0];
            disp_on <= 1'b1;
          end
          default: begin
            disp_char <= `FSD_CH_BLANK; // [R20] gap
            disp_on <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // apb slave, one wait-free access phase
  // register select from a bus address, all zero when unmapped
  function [5:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr == `FSD_CTRL_OFF) begin
        reg_sel = 6'h01;
      end else if (addr == `FSD_STAT_OFF) begin
        reg_sel = 6'h02;
      end else if (addr == `FSD_CODE_OFF) begin
        reg_sel = 6'h04;
      end else if (addr == `FSD_FLT_OFF) begin
        reg_sel = 6'h08;
      end else if (addr == `FSD_STEP_OFF) begin
        reg_sel = 6'h10;
      end else if (addr == `FSD_FLE_OFF) begin
        reg_sel = 6'h20;
      end else begin
        reg_sel = 6'h00;
      end
    end
  endfunction

  wire [5:0] sel = reg_sel(paddr);

  // read data and answer, decoded at the setup edge
  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(|sel); // unmapped address refused
      if (psel & ~penable) begin
        if (sel[0]) begin
          prdata <= {28'h000_0000, ctrl_q};
        end else if (sel[1]) begin
          prdata <= {28'h000_0000, pwr_q, |nonfatal_q, |fatal_q, en_q};
        end else if (sel[2]) begin
          prdata <= {19'h0_0000, code_q};
        end else if (sel[3]) begin
          prdata <= {17'h0_0000, nonfatal_q, fatal_q};
        end else if (sel[4]) begin
          prdata <= step_q;
        end else if (sel[5]) begin
          prdata <= fle_q;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // register writes, taken at the access edge with ready
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= 4'h0;
      step_q <= `FSD_STEP_RST;
      fle_q <= `FSD_FLE_RST;
    end else if (psel & penable & pready & pwrite) begin
      if (sel[0]) begin
        ctrl_q <= pwdata[3:0];
      end else if (sel[4]) begin
        step_q <= pwdata[STEP_W-1:0];
      end else if (sel[5]) begin
        fle_q <= pwdata;
      end
    end
  end

endmodule

// >>> tb/fsd_checker.sv
// port assertions for the fault/status display supervisor
`timescale 1ns/1ps
`include "fsd_map.vh"
module fsd_checker (
  input wire ref_clk,
  input wire rst,
  input wire enable_in,
  input wire [6:0] fatal_in,
  input wire [6:0] nonfatal_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire amp_en,
  input wire [3:0] disp_char
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // power stage against fault sources and enable input
  fatal_off_a: assert property (fatal_in != 7'h00 |=> !amp_en)
    else $error("power stage on after fatal input");
  nonfatal_off_a: assert property (nonfatal_in[5:1] != 5'h00 |=> !amp_en)
    else $error("power stage on after non-fatal input");
  enable_gate_a: assert property ($rose(amp_en) |-> $past(enable_in) && $past(enable_in, 2))
    else $error("power stage on without enable input");
  fault_block_a: assert property ($rose(amp_en) |-> $past(fatal_in) == 7'h00)
    else $error("power stage on while fatal input present");
  fatal_show_a: assert property (fatal_in[0] [*4] |=> disp_char inside {`FSD_CH_F, 4'h0, `FSD_CH_BLANK})
    else $error("top fatal fault not on display");
  // register bus answers
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
endmodule
bind fsd_supervisor fsd_checker fsd_checker_inst (.*);

// >>> tb/fsd_disp_model.sv
// seven-segment display model keeping a log of shown characters
`timescale 1ns/1ps
`include "fsd_map.vh"
module fsd_disp_model #(
  parameter HOLD = 4
) (
  input wire ref_clk,
  input wire [3:0] disp_char,
  input wire disp_on,
  output reg [15:0] hist
);
  reg [3:0] last_q;
  integer run_q;
  wire [3:0] seen = disp_on ? disp_char : `FSD_CH_BLANK;
  initial begin
    hist = 16'h0000;
    last_q = `FSD_CH_BLANK;
    run_q = 0;
  end
  // log each change, and a repeat once a full step time has passed
  always @(posedge ref_clk) begin
    if (seen != last_q || run_q == HOLD - 1) begin
      hist <= {hist[11:0], seen};
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
    last_q <= seen;
  end
endmodule

// >>> tb/fsd_supervisor_tb.sv
// self-checking bench for the fault/status display supervisor
`timescale 1ns/1ps
`include "fsd_map.vh"
module fsd_supervisor_tb;
  logic ref_clk, rst, pwr_on_n, enable_in, cur_sat, phasing, limit_cw, limit_ccw;
  logic psel, penable, pwrite, pready, pslverr, amp_en, disp_on, err_q;
  logic [6:0] fatal_in, nonfatal_in;
  logic [11:0] paddr;
  logic [31:0] follow_err, pwdata, prdata, rd_q;
  logic [3:0] disp_char;
  logic [15:0] hist;
  logic [7:0] nf_code [6] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h56, 8'h57};
  integer error_cnt = 0, checks = 0, i;
  fsd_supervisor #(.SAT_CYCLES(20)) fsd_supervisor_inst (.*);
  fsd_disp_model #(.HOLD(4)) fsd_disp_model_inst (.*);
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus transfer, answer taken at the ready edge
  task apb(input wr, input [11:0] a, input [31:0] d);
    integer n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
    {err_q, rd_q} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    @(posedge ref_clk);
  endtask
  // bounded wait until the last four shown characters match
  task wait_hist(input [15:0] exp);
    integer n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n = n + 1;
    end while (hist !== exp && n < 100);
    check(hist, exp);
    @(posedge ref_clk);
  endtask
  // optional power cycle, then enable removed and given again
  task reen(input pc);
    if (pc) begin
      pwr_on_n <= 1'b1;
      cyc(4);
      pwr_on_n <= 1'b0;
      cyc(4);
    end
    enable_in <= 1'b0;
    cyc(4);
    enable_in <= 1'b1;
    cyc(20);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(100000);
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  // ==========================================
  // main sequence
  initial begin
    {rst, pwr_on_n, enable_in, cur_sat, phasing, limit_cw, limit_ccw, psel, penable, pwrite} = 10'h200;
    {fatal_in, nonfatal_in, paddr, pwdata, follow_err} = 90'h0;
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    apb(1'b0, `FSD_CTRL_OFF, 32'h0000_0000);
    check(rd_q, `FSD_CTRL_RST);
    apb(1'b0, `FSD_STEP_OFF, 32'h0000_0000);
    check(rd_q, `FSD_STEP_RST);
    apb(1'b0, `FSD_FLE_OFF, 32'h0000_0000);
    check(rd_q, `FSD_FLE_RST);
    apb(1'b1, `FSD_STEP_OFF, 32'h0000_0003);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check(err_q, 1'b1);
    enable_in <= 1'b1;
    wait_hist(16'hA99F);
    check(amp_en, 1'b0);
    $display("unconfigured test done");
    apb(1'b1, `FSD_CTRL_OFF, 32'h0000_0001);
    wait_hist(16'hDDDD);
    check(amp_en, 1'b1);
    apb(1'b1, `FSD_CTRL_OFF, 32'h0000_0003);
    wait_hist(16'hCCCC);
    check(amp_en, 1'b0);
    enable_in <= 1'b0;
    apb(1'b1, `FSD_CTRL_OFF, 32'h0000_0001);
    wait_hist(16'hCCCC);
    enable_in <= 1'b1;
    {limit_cw, limit_ccw} <= 2'b11;
    wait_hist(16'hB01F);
    limit_cw <= 1'b0;
    wait_hist(16'hB02F);
    {limit_ccw, phasing} <= 2'b01;
    wait_hist(16'hEEEE);
    phasing <= 1'b0;
    $display("status test done");
    apb(1'b1, `FSD_CTRL_OFF, 32'h0000_0005);
    nonfatal_in <= 7'h01;
    cyc(20);
    wait_hist(16'hDDDD);
    nonfatal_in <= 7'h00;
    apb(1'b1, `FSD_CTRL_OFF, 32'h0000_0001);
    for (i = 0; i < 6; i = i + 1) begin
      nonfatal_in <= 7'h3F << i;
      wait_hist({4'hA, nf_code[i], 4'hF});
      check(amp_en, 1'b0);
      nonfatal_in <= 7'h00;
      cyc(20);
      wait_hist({4'hA, nf_code[i], 4'hF});
      reen(1'b0);
      wait_hist(16'hDDDD);
    end
    apb(1'b1, `FSD_FLE_OFF, 32'h0000_0010);
    follow_err <= 32'h0000_0010;
    cyc(20);
    wait_hist(16'hDDDD);
    apb(1'b1, `FSD_CTRL_OFF, 32'h0000_0009);
    wait_hist(16'hA55F);
    follow_err <= 32'h0000_0000;
    reen(1'b0);
    wait_hist(16'hDDDD);
    $display("non-fatal test done");
    cur_sat <= 1'b1;
    cyc(10);
    cur_sat <= 1'b0;
    cyc(20);
    wait_hist(16'hDDDD);
    cur_sat <= 1'b1;
    wait_hist(16'hA04F);
    fatal_in <= 7'h01;
    wait_hist(16'hA00F);
    {cur_sat, fatal_in} <= 8'h00;
    reen(1'b0);
    wait_hist(16'hA00F);
    apb(1'b0, `FSD_STAT_OFF, 32'h0000_0000);
    check(rd_q, 32'h0000_0002);
    apb(1'b0, `FSD_FLT_OFF, 32'h0000_0000);
    check(rd_q, 32'h0000_0011);
    apb(1'b0, `FSD_CODE_OFF, 32'h0000_0000);
    check(rd_q, 32'h0000_1A00);
    for (i = 0; i < 7; i = i + 1) begin
      reen(1'b1);
      wait_hist(16'hDDDD);
      fatal_in <= 7'h7F << i;
      wait_hist(16'hA00F | (i << 4));
      check(amp_en, 1'b0);
      fatal_in <= 7'h00;
    end
    $display("fatal test done");
    end_of_test;
  end
endmodule
